// File: verilog/tsm_pin_mux.sv
`timescale 1ns/1ps
`include "tsm_map.svh"

// How it works
// - remap bit 7 moves timer channel 4 from port A bit 2 to port B bit 4.
// - remap bit 4 clear keeps timer channel 1 on port A bit 0.
// - remap bit 6 clear keeps timer channel 3 on port A bit 1.
// - remap bit 5 clear keeps timer channel 2 on port A bit 3.
// - each channel captures from the pin its remap bit selects.
// - timer drives a pin only if enabled and field picks alternate output.
// - serial 1 RTS on port B bit 4 only when channel 4 is not there.
// - serial 2 outputs on shared port A pins only when timer is not there.
// - serial 1 RTS needs its enable bit 5 and UART mode.
// - serial 2 SPI master drives data out and clock; slave takes them in.
// - SPI slaves read slave select on port B bit 4 and port A bit 3.
// - serial 2 slave drives data on port A bit 1; master reads it there.
// - two-wire data and clock need the open-drain alternate function.
// - only the chosen serial protocol reaches the pins.
// - analog function on port A bits 0 and 1 connects the USB pads.
// - four-bit function field per pin from the port config registers.
// - external interrupts C and D each pick any pin by selector.

module tsm_pin_mux #(
    parameter logic HAS_USB = 1'b1
) (
    input  wire logic                  CLK,
    input  wire logic                  NRST,
    input  wire logic [`TSM_NPIN-1:0]  PIN_IN,
    output logic      [`TSM_NPIN-1:0]  PIN_OUT,
    output logic      [`TSM_NPIN-1:0]  PIN_OE,
    input  wire logic [7:0]            TIMER2_REMAP,
    input  wire logic [3:0]            TIMER2_CAPTURE_ENABLE,
    input  wire logic [15:0]           PORTA_CONFIG_LOW,
    input  wire logic [3:0]            PORTB_CONFIG_HIGH,
    input  wire logic [7:0]            SERIAL1_UART_CONFIG,
    input  wire logic [7:0]            SERIAL1_SPI_CONFIG,
    input  wire logic [7:0]            SERIAL2_SPI_CONFIG,
    input  wire logic [1:0]            SERIAL1_MODE,
    input  wire logic [1:0]            SERIAL2_MODE,
    input  wire logic [`TSM_NPIN-1:0]  GPIO_OUT,
    output logic      [`TSM_NPIN-1:0]  GPIO_IN,
    input  wire logic [3:0]            TIMER2_CHANNEL_OUT,
    input  wire logic [2:0]            TIMER2_ALT_PIN_IN,
    output logic      [3:0]            TIMER2_CHANNEL_IN,
    input  wire logic                  SERIAL1_RTS_N,
    output logic                       SERIAL1_SLAVE_SELECT_N,
    input  wire tsm_pkg::tsm_s2_t      SERIAL2_TX,
    output tsm_pkg::tsm_s2_t           SERIAL2_RX,
    output logic                       SERIAL2_SLAVE_SELECT_N,
    output logic                       USB_MINUS_PAD,
    output logic                       USB_PLUS_PAD,
    input  wire logic [`TSM_SEL_W-1:0] EXT_IRQ_C_PIN_SELECT,
    input  wire logic [`TSM_SEL_W-1:0] EXT_IRQ_D_PIN_SELECT,
    output logic                       EXT_INTERRUPT_C,
    output logic                       EXT_INTERRUPT_D
);

    // pick one synchronised pin; selector beyond the pins reads low
    function automatic logic pick_pin(
        input logic [`TSM_NPIN-1:0]  pins,
        input logic [`TSM_SEL_W-1:0] sel
    );
        logic r;
        r = `TSM_IDLE_LO;
        for (int i = 0; i < `TSM_NPIN; i++) begin
            if (sel == i[`TSM_SEL_W-1:0]) begin
                r = pins[i];
            end
        end
        return r;
    endfunction

    // timer channel sitting on its port A home pin with output on
    function automatic logic home_drive(
        input logic en,
        input logic remap
    );
        return en && !remap;
    endfunction

    logic [1:0]                rst_q;
    logic                      rst_n;
    tsm_pkg::tsm_fn_t          fn [`TSM_NPIN];
    logic [`TSM_NPIN-1:0]      psync;
    logic [`TSM_NPIN-1:0]      din;
    logic [`TSM_NPIN-1:0]      alt_o;
    logic [`TSM_NPIN-1:0]      alt_en;
    logic [`TSM_NPIN-1:0]      is_alt;
    logic [`TSM_NPIN-1:0]      is_od;
    logic [`TSM_NPIN-1:0]      is_ana;
    logic [3:0]                t_home;
    logic                      t4_remote;
    logic                      s1_uart;
    logic                      s1_spi;
    logic                      s1_slave;
    logic                      s1_rts_on;
    logic                      s2_spi;
    logic                      s2_twi;
    logic                      s2_master;
    logic                      s2_slave;
    tsm_pkg::tsm_main_st_t     q;
    tsm_pkg::tsm_main_st_t     d;

    // reset release through two flops, assertion stays immediate
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            rst_q <= `TSM_RSTSYNC_0;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    assign rst_n = rst_q[1];

    assign fn[`TSM_PA0] =
        PORTA_CONFIG_LOW[`TSM_FN_PA0_LSB +: `TSM_FN_W];
    assign fn[`TSM_PA1] =
        PORTA_CONFIG_LOW[`TSM_FN_PA1_LSB +: `TSM_FN_W];
    assign fn[`TSM_PA2] =
        PORTA_CONFIG_LOW[`TSM_FN_PA2_LSB +: `TSM_FN_W];
    assign fn[`TSM_PA3] =
        PORTA_CONFIG_LOW[`TSM_FN_PA3_LSB +: `TSM_FN_W];
    assign fn[`TSM_PB4] =
        PORTB_CONFIG_HIGH[`TSM_FN_PB4_LSB +: `TSM_FN_W];

    always_comb begin
        for (int i = 0; i < `TSM_NPIN; i++) begin
            is_alt[i] = tsm_pkg::tsm_is_alt(fn[i]);
            is_od[i]  = fn[i] == `TSM_FN_ALT_OD;
            is_ana[i] = tsm_pkg::tsm_is_analog(fn[i]);
        end
    end

    // analog pins give no digital input, so nothing toggles on noise
    assign din = psync & ~is_ana;

    assign s1_uart   = SERIAL1_MODE == tsm_pkg::TSM_UART;
    assign s1_spi    = SERIAL1_MODE == tsm_pkg::TSM_SPI;
    assign s2_spi    = SERIAL2_MODE == tsm_pkg::TSM_SPI;
    assign s2_twi    = SERIAL2_MODE == tsm_pkg::TSM_TWI;
    // master or slave from the spi config bit
    assign s1_slave  = s1_spi && !SERIAL1_SPI_CONFIG[`TSM_SPI_MASTER];
    assign s2_master = s2_spi && SERIAL2_SPI_CONFIG[`TSM_SPI_MASTER];
    assign s2_slave  = s2_spi && !SERIAL2_SPI_CONFIG[`TSM_SPI_MASTER];

    // channel 1 at home when remap clear
    assign t_home[`TSM_CH1] = home_drive(
        TIMER2_CAPTURE_ENABLE[`TSM_CH1], TIMER2_REMAP[`TSM_RMP_CH1]);
    // channel 2 at home when remap clear
    assign t_home[`TSM_CH2] = home_drive(
        TIMER2_CAPTURE_ENABLE[`TSM_CH2], TIMER2_REMAP[`TSM_RMP_CH2]);
    // channel 3 at home when remap clear
    assign t_home[`TSM_CH3] = home_drive(
        TIMER2_CAPTURE_ENABLE[`TSM_CH3], TIMER2_REMAP[`TSM_RMP_CH3]);
    // channel 4 home or moved to port B
    assign t_home[`TSM_CH4] = home_drive(
        TIMER2_CAPTURE_ENABLE[`TSM_CH4], TIMER2_REMAP[`TSM_RMP_CH4]);
    assign t4_remote = TIMER2_CAPTURE_ENABLE[`TSM_CH4]
                    && TIMER2_REMAP[`TSM_RMP_CH4];

    // rts only with its enable and uart mode
    assign s1_rts_on = s1_uart && SERIAL1_UART_CONFIG[`TSM_RTS_EN];

    // source and request for every pin; timer wins where it owns the pin
    always_comb begin
        alt_o  = '0;
        alt_en = '0;

        // serial 2 data out only if channel 1 is away
        if (t_home[`TSM_CH1]) begin
            alt_o[`TSM_PA0]  = TIMER2_CHANNEL_OUT[`TSM_CH1];
            alt_en[`TSM_PA0] = 1'b1;
        end else if (s2_master) begin
            alt_o[`TSM_PA0]  = SERIAL2_TX.master_out;
            alt_en[`TSM_PA0] = 1'b1;
        end

        // slave data out shares the pin with channel 3
        if (t_home[`TSM_CH3]) begin
            alt_o[`TSM_PA1]  = TIMER2_CHANNEL_OUT[`TSM_CH3];
            alt_en[`TSM_PA1] = 1'b1;
        end else if (s2_slave) begin
            alt_o[`TSM_PA1]  = SERIAL2_TX.master_in;
            alt_en[`TSM_PA1] = 1'b1;
        end else if (s2_twi) begin
            // two-wire data only via open-drain field
            alt_o[`TSM_PA1]  = SERIAL2_TX.twowire_data;
            alt_en[`TSM_PA1] = is_od[`TSM_PA1];
        end

        // master clock out shares with channel 4
        if (t_home[`TSM_CH4]) begin
            alt_o[`TSM_PA2]  = TIMER2_CHANNEL_OUT[`TSM_CH4];
            alt_en[`TSM_PA2] = 1'b1;
        end else if (s2_master) begin
            alt_o[`TSM_PA2]  = SERIAL2_TX.spi_clock;
            alt_en[`TSM_PA2] = 1'b1;
        end else if (s2_twi) begin
            // two-wire clock only via open-drain field
            alt_o[`TSM_PA2]  = SERIAL2_TX.twowire_clock;
            alt_en[`TSM_PA2] = is_od[`TSM_PA2];
        end

        // port A bit 3 carries only channel 2 as an output
        if (t_home[`TSM_CH2]) begin
            alt_o[`TSM_PA3]  = TIMER2_CHANNEL_OUT[`TSM_CH2];
            alt_en[`TSM_PA3] = 1'b1;
        end

        // rts yields port B bit 4 to a remapped channel 4
        if (t4_remote) begin
            alt_o[`TSM_PB4]  = TIMER2_CHANNEL_OUT[`TSM_CH4];
            alt_en[`TSM_PB4] = 1'b1;
        end else if (s1_rts_on) begin
            alt_o[`TSM_PB4]  = SERIAL1_RTS_N;
            alt_en[`TSM_PB4] = 1'b1;
        end

        // nothing drives unless the field selects alternate
        alt_en = alt_en & is_alt;
    end

    // one cell per pin: input synchroniser and output register
    for (genvar p = 0; p < `TSM_NPIN; p++) begin : g_pin
        tsm_pin_cell u_cell (
            .clk      (CLK),
            .rst_n    (rst_n),
            .pad_i    (PIN_IN[p]),
            .fn       (fn[p]),
            .gpio_o   (GPIO_OUT[p]),
            .alt_o    (alt_o[p]),
            .alt_en   (alt_en[p]),
            .pad_o    (PIN_OUT[p]),
            .pad_oe   (PIN_OE[p]),
            .pad_sync (psync[p])
        );
    end

    always_comb begin
        d = q;

        d.timer_in[`TSM_CH1] = TIMER2_REMAP[`TSM_RMP_CH1]
                             ? TIMER2_ALT_PIN_IN[0]
                             : din[`TSM_PA0];
        d.timer_in[`TSM_CH2] = TIMER2_REMAP[`TSM_RMP_CH2]
                             ? TIMER2_ALT_PIN_IN[1]
                             : din[`TSM_PA3];
        d.timer_in[`TSM_CH3] = TIMER2_REMAP[`TSM_RMP_CH3]
                             ? TIMER2_ALT_PIN_IN[2]
                             : din[`TSM_PA1];
        d.timer_in[`TSM_CH4] = TIMER2_REMAP[`TSM_RMP_CH4]
                             ? din[`TSM_PB4]
                             : din[`TSM_PA2];

        // slave selects idle high outside slave mode
        d.s1_ssel_n = s1_slave ? din[`TSM_PB4] : `TSM_IDLE_HI;
        d.s2_ssel_n = s2_slave ? din[`TSM_PA3] : `TSM_IDLE_HI;

        // slave side takes data and clock in
        d.s2.master_out = s2_slave ? din[`TSM_PA0] : `TSM_IDLE_LO;
        d.s2.spi_clock  = s2_slave ? din[`TSM_PA2] : `TSM_IDLE_LO;
        // master reads its data in on port A bit 1
        d.s2.master_in  = s2_master ? din[`TSM_PA1] : `TSM_IDLE_LO;

        // released bus reads high when not in two-wire
        d.s2.twowire_data  = s2_twi ? din[`TSM_PA1] : `TSM_IDLE_HI;
        d.s2.twowire_clock = s2_twi ? din[`TSM_PA2] : `TSM_IDLE_HI;

        d.gpio_in = din;

        d.irq_c = pick_pin(din, EXT_IRQ_C_PIN_SELECT);
        d.irq_d = pick_pin(din, EXT_IRQ_D_PIN_SELECT);

        // analog field connects the usb pads
        d.usb_minus = HAS_USB && is_ana[`TSM_PA0];
        d.usb_plus  = HAS_USB && is_ana[`TSM_PA1];
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            q           <= '0;
            q.s1_ssel_n <= `TSM_IDLE_HI;
            q.s2_ssel_n <= `TSM_IDLE_HI;
            q.s2.twowire_data  <= `TSM_IDLE_HI;
            q.s2.twowire_clock <= `TSM_IDLE_HI;
        end else begin
            q <= d;
        end
    end

    assign TIMER2_CHANNEL_IN      = q.timer_in;
    assign SERIAL1_SLAVE_SELECT_N = q.s1_ssel_n;
    assign SERIAL2_RX             = q.s2;
    assign SERIAL2_SLAVE_SELECT_N = q.s2_ssel_n;
    assign GPIO_IN                = q.gpio_in;
    assign EXT_INTERRUPT_C        = q.irq_c;
    assign EXT_INTERRUPT_D        = q.irq_d;
    assign USB_MINUS_PAD          = q.usb_minus;
    assign USB_PLUS_PAD           = q.usb_plus;

endmodule

// File: pkg/tsm_map.svh
`ifndef TSM_MAP_SVH
`define TSM_MAP_SVH

// pin slots handled by the block
`define TSM_NPIN        5
`define TSM_PA0         0
`define TSM_PA1         1
`define TSM_PA2         2
`define TSM_PA3         3
`define TSM_PB4         4

// timer 2 channel index inside the capture enable and channel vectors
`define TSM_CH1         0
`define TSM_CH2         1
`define TSM_CH3         2
`define TSM_CH4         3

// timer 2 remap bit positions
`define TSM_RMP_CH1     4
`define TSM_RMP_CH2     5
`define TSM_RMP_CH3     6
`define TSM_RMP_CH4     7

// serial controller configuration bits
`define TSM_RTS_EN      5
`define TSM_SPI_MASTER  4

// per-pin function field layout and codes
`define TSM_FN_W        4
`define TSM_FN_PA0_LSB  0
`define TSM_FN_PA1_LSB  4
`define TSM_FN_PA2_LSB  8
`define TSM_FN_PA3_LSB  12
`define TSM_FN_PB4_LSB  0
`define TSM_FN_ANALOG   4'h0
`define TSM_FN_OUT      4'h1
`define TSM_FN_IN       4'h4
`define TSM_FN_OUT_OD   4'h5
`define TSM_FN_ALT      4'h9
`define TSM_FN_ALT_OD   4'hd

// serial controller mode field codes
`define TSM_MODE_OFF    2'h0
`define TSM_MODE_UART   2'h1
`define TSM_MODE_SPI    2'h2
`define TSM_MODE_TWI    2'h3

// idle levels and selector width
`define TSM_IDLE_HI     1'b1
`define TSM_IDLE_LO     1'b0
`define TSM_SEL_W       3
`define TSM_RSTSYNC_0   2'h0

`endif

// File: pkg/tsm_pkg.sv
`include "tsm_map.svh"

package tsm_pkg;

    typedef logic [`TSM_FN_W-1:0] tsm_fn_t;

    typedef enum logic [1:0] {
        TSM_OFF  = `TSM_MODE_OFF,
        TSM_UART = `TSM_MODE_UART,
        TSM_SPI  = `TSM_MODE_SPI,
        TSM_TWI  = `TSM_MODE_TWI
    } tsm_mode_t;

    typedef struct packed {
        logic [1:0] sync;
        logic       o;
        logic       oe;
    } tsm_cell_st_t;

    typedef struct packed {
        logic [`TSM_NPIN-1:0] in;
        logic [`TSM_NPIN-1:0] out;
        logic [`TSM_NPIN-1:0] oe;
    } tsm_pins_t;

    typedef struct packed {
        logic master_out;
        logic master_in;
        logic spi_clock;
        logic twowire_data;
        logic twowire_clock;
    } tsm_s2_t;

    typedef struct packed {
        logic [3:0] timer_in;
        logic       s1_ssel_n;
        tsm_s2_t    s2;
        logic       s2_ssel_n;
        logic [`TSM_NPIN-1:0] gpio_in;
        logic       irq_c;
        logic       irq_d;
        logic       usb_minus;
        logic       usb_plus;
    } tsm_main_st_t;

    function automatic logic tsm_is_alt(input tsm_fn_t fn);
        return (fn == `TSM_FN_ALT) || (fn == `TSM_FN_ALT_OD);
    endfunction

    function automatic logic tsm_is_analog(input tsm_fn_t fn);
        return fn == `TSM_FN_ANALOG;
    endfunction

endpackage

// File: verilog/tsm_pin_cell.sv
`timescale 1ns/1ps
`include "tsm_map.svh"

module tsm_pin_cell (
    input  wire logic            clk,
    input  wire logic            rst_n,
    input  wire logic            pad_i,
    input  wire tsm_pkg::tsm_fn_t fn,
    input  wire logic            gpio_o,
    input  wire logic            alt_o,
    input  wire logic            alt_en,
    output logic                 pad_o,
    output logic                 pad_oe,
    output logic                 pad_sync
);

    tsm_pkg::tsm_cell_st_t q;
    tsm_pkg::tsm_cell_st_t d;

    always_comb begin
        d = q;
        // stage 0 feeds only stage 1
        d.sync = {q.sync[0], pad_i};
        d.o    = `TSM_IDLE_LO;
        d.oe   = `TSM_IDLE_LO;
        if (tsm_pkg::tsm_is_analog(fn)) begin
            // analog: digital driver stays off
            d.oe = `TSM_IDLE_LO;
        end else if (tsm_pkg::tsm_is_alt(fn)) begin
            if (alt_en && fn == `TSM_FN_ALT_OD) begin
                d.oe = ~alt_o;
            end else if (alt_en) begin
                d.o  = alt_o;
                d.oe = 1'b1;
            end
        end else if (fn == `TSM_FN_OUT) begin
            d.o  = gpio_o;
            d.oe = 1'b1;
        end else if (fn == `TSM_FN_OUT_OD) begin
            d.oe = ~gpio_o;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign pad_o    = q.o;
    assign pad_oe   = q.oe;
    assign pad_sync = q.sync[1];

endmodule

// File: verification/tsm_pin_mux_sva.sv
`timescale 1ns/1ps

module tsm_pin_mux_chk #(
    parameter logic HAS_USB = 1'b1
) (
    input wire logic             CLK,
    input wire logic             NRST,
    input wire logic [4:0]       PIN_OUT,
    input wire logic [4:0]       PIN_OE,
    input wire logic [7:0]       TIMER2_REMAP,
    input wire logic [3:0]       TIMER2_CAPTURE_ENABLE,
    input wire logic [15:0]      PORTA_CONFIG_LOW,
    input wire logic [3:0]       PORTB_CONFIG_HIGH,
    input wire logic [7:0]       SERIAL1_UART_CONFIG,
    input wire logic [7:0]       SERIAL2_SPI_CONFIG,
    input wire logic [1:0]       SERIAL1_MODE,
    input wire logic [1:0]       SERIAL2_MODE,
    input wire logic [4:0]       GPIO_OUT,
    input wire logic [3:0]       TIMER2_CHANNEL_OUT,
    input wire logic             SERIAL1_RTS_N,
    input wire tsm_pkg::tsm_s2_t SERIAL2_TX,
    input wire logic             USB_MINUS_PAD
);
    logic [1:0] up_q;
    wire        ok = up_q == 2'h3;
    wire  [3:0] f0 = PORTA_CONFIG_LOW[3:0];
    wire  [3:0] f1 = PORTA_CONFIG_LOW[7:4];
    wire  [3:0] f2 = PORTA_CONFIG_LOW[11:8];
    wire  [7:0] rm = TIMER2_REMAP;
    wire  [3:0] en = TIMER2_CAPTURE_ENABLE;

    // outputs mean nothing until the synced reset has let go
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            up_q <= 2'h0;
        end else if (!ok) begin
            up_q <= up_q + 2'h1;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);

    chk_ch1_home: assert property (ok && !rm[4] && en[0] && f0 == 4'h9
        |=> PIN_OE[0] && PIN_OUT[0] == $past(TIMER2_CHANNEL_OUT[0]))
        else $error("channel 1 not on its home pin");
    chk_ch4_moved: assert property (ok && rm[7] && en[3]
        && PORTB_CONFIG_HIGH == 4'h9
        |=> PIN_OE[4] && PIN_OUT[4] == $past(TIMER2_CHANNEL_OUT[3]))
        else $error("channel 4 not on remapped pin");
    chk_ch4_home: assert property (ok && !rm[7] && en[3] && f2 == 4'h9
        |=> PIN_OE[2] && PIN_OUT[2] == $past(TIMER2_CHANNEL_OUT[3]))
        else $error("channel 4 not on home pin");
    chk_fn_nodrive: assert property (ok && (f0 == 4'h0 || f0 == 4'h4)
        |=> !PIN_OE[0])
        else $error("pin driven without output function");
    chk_rts_gate: assert property (ok && !(rm[7] && en[3])
        && PORTB_CONFIG_HIGH == 4'h9
        |=> PIN_OE[4] == ($past(SERIAL1_UART_CONFIG[5])
        && $past(SERIAL1_MODE) == 2'h1)
        && (!PIN_OE[4] || PIN_OUT[4] == $past(SERIAL1_RTS_N)))
        else $error("rts drive wrong");
    chk_spi_clock: assert property (ok && !(!rm[7] && en[3])
        && f2 == 4'h9 && SERIAL2_MODE == 2'h2 && SERIAL2_SPI_CONFIG[4]
        |=> PIN_OE[2] && PIN_OUT[2] == $past(SERIAL2_TX.spi_clock))
        else $error("spi master clock not driven");
    chk_twi_od: assert property (ok && !(!rm[6] && en[2])
        && f1 == 4'hd && SERIAL2_MODE == 2'h3
        |=> !PIN_OUT[1] && PIN_OE[1] == !$past(SERIAL2_TX.twowire_data))
        else $error("two-wire data not open drain");
    chk_usb_pad: assert property (ok
        |=> USB_MINUS_PAD == (HAS_USB && $past(f0) == 4'h0))
        else $error("usb minus pad wrong");
    chk_port_out: assert property (ok && f2 == 4'h1
        |=> PIN_OE[2] && PIN_OUT[2] == $past(GPIO_OUT[2]))
        else $error("port output not driven");
endmodule

bind tsm_pin_mux tsm_pin_mux_chk #(.HAS_USB(HAS_USB)) i_chk (
    .CLK, .NRST, .PIN_OUT, .PIN_OE, .TIMER2_REMAP, .TIMER2_CAPTURE_ENABLE,
    .PORTA_CONFIG_LOW, .PORTB_CONFIG_HIGH, .SERIAL1_UART_CONFIG,
    .SERIAL2_SPI_CONFIG, .SERIAL1_MODE, .SERIAL2_MODE, .GPIO_OUT,
    .TIMER2_CHANNEL_OUT, .SERIAL1_RTS_N, .SERIAL2_TX, .USB_MINUS_PAD
);

// File: verification/tsm_ext_dev.sv
`timescale 1ns/1ps

module tsm_ext_dev (
    input  wire logic [4:0] pad_out,
    input  wire logic [4:0] pad_oe,
    input  wire logic [4:0] far_lvl,
    output logic      [4:0] pad_lvl
);
    // wired-and pads
    // far side only pulls low or lets the pull-up win
    assign pad_lvl = (pad_out | ~pad_oe) & far_lvl;
endmodule

// File: verification/tsm_pin_mux_bench.sv
`timescale 1ns/1ps

module tsm_pin_mux_bench;
    typedef struct {
        string nm;
        int    b;
        logic  v;
    } tsm_note_t;
    localparam int OE = 25, OU = 20, GI = 15, CI = 11, S1 = 10;
    localparam int RX = 5, S2 = 4, UM = 3, UP = 2, IC = 1, ID = 0;
    logic             clk = 1'b0;
    logic             nrst = 1'b0;
    logic [7:0]       rmp = 8'h0, u1 = 8'h0, s1 = 8'h0, s2 = 8'h0;
    logic [3:0]       ce = 4'h0, pb = 4'h4, cho = 4'h0, chin;
    logic [15:0]      pa = 16'h4444;
    logic [1:0]       m1 = 2'h0, m2 = 2'h0;
    logic [4:0]       gout = 5'h0, ext = 5'h1f, pin, pout, poe, gin;
    logic [2:0]       alt = 3'h0, isc = 3'h0, isd = 3'h0;
    logic             rts = 1'b1, ss1, ss2, um, up, irc, ird;
    tsm_pkg::tsm_s2_t tx = '0, rx;
    logic [29:0]      obs;
    tsm_note_t        q[$];
    int               seed = 71, miscompares = 0, comparisons = 0;
    int               chn[5] = '{0, 2, 3, 1, 3};
    int               pof[4] = '{0, 3, 1, 2};

    assign obs = {poe, pout, gin, chin, ss1, rx, ss2, um, up, irc, ird};

    tsm_pin_mux i_dut (
        .CLK(clk), .NRST(nrst), .PIN_IN(pin), .PIN_OUT(pout), .PIN_OE(poe),
        .TIMER2_REMAP(rmp), .TIMER2_CAPTURE_ENABLE(ce),
        .PORTA_CONFIG_LOW(pa), .PORTB_CONFIG_HIGH(pb),
        .SERIAL1_UART_CONFIG(u1), .SERIAL1_SPI_CONFIG(s1),
        .SERIAL2_SPI_CONFIG(s2), .SERIAL1_MODE(m1), .SERIAL2_MODE(m2),
        .GPIO_OUT(gout), .GPIO_IN(gin), .TIMER2_CHANNEL_OUT(cho),
        .TIMER2_ALT_PIN_IN(alt), .TIMER2_CHANNEL_IN(chin),
        .SERIAL1_RTS_N(rts), .SERIAL1_SLAVE_SELECT_N(ss1),
        .SERIAL2_TX(tx), .SERIAL2_RX(rx), .SERIAL2_SLAVE_SELECT_N(ss2),
        .USB_MINUS_PAD(um), .USB_PLUS_PAD(up),
        .EXT_IRQ_C_PIN_SELECT(isc), .EXT_IRQ_D_PIN_SELECT(isd),
        .EXT_INTERRUPT_C(irc), .EXT_INTERRUPT_D(ird)
    );
    tsm_ext_dev i_far (
        .pad_out(pout), .pad_oe(poe), .far_lvl(ext), .pad_lvl(pin)
    );

    always #20 clk = ~clk;

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic ex(input string nm, input int b, input logic v);
        q.push_back('{nm, b, v});
    endtask

    // level the pin settles to with our drive and the far side's
    function automatic logic lv(input int p, input logic d, input logic o);
        return (d ? o : 1'b1) & ext[p];
    endfunction

    task automatic cmp_bit(input tsm_note_t n);
        comparisons++;
        if (obs[n.b] !== n.v) begin
            miscompares++;
            $display("MISMATCH %s bit %0d expected %b seen %b",
                     n.nm, n.b, n.v, obs[n.b]);
        end
    endtask

    // sampled mid-cycle, well clear of the launching edge
    always @(negedge clk) begin
        while (q.size() > 0) begin
            cmp_bit(q.pop_front());
        end
    end

    task automatic finish_test;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        int   c;
        int   p;
        logic own;
        tick(1);
        ex("ss1", S1, 1'b1);
        ex("oe", OE, 1'b0);
        tick(2);
        nrst = 1'b1;
        tick(4);
        pa = 16'h9999;
        pb = 4'h9;
        for (int r = 0; r < 12; r++) begin
            rmp = 8'($random(seed));
            ce = 4'($random(seed));
            cho = 4'($random(seed));
            alt = 3'($random(seed));
            ext = 5'($random(seed));
            tick(4);
            for (int k = 0; k < 5; k++) begin
                c = chn[k];
                own = ce[c] && (rmp[4 + c] == (k == 4));
                ex("oe", OE + k, own);
                if (own) ex("out", OU + k, cho[c]);
                ex("gpio", GI + k, lv(k, own, cho[c]));
            end
            for (int k = 0; k < 4; k++) begin
                p = (k == 3 && rmp[7]) ? 4 : pof[k];
                own = k < 3 && rmp[4 + k];
                ex("cap", CI + k, own ? alt[k] : lv(p, ce[k], cho[k]));
            end
        end
        rmp = 8'h0;
        ce = 4'h0;
        ext = 5'h1f;
        for (int k = 0; k < 8; k++) begin
            m1 = k[1:0];
            u1 = k[2] ? 8'h20 : 8'h00;
            rts = 1'($random(seed));
            tick(2);
            own = k[2] && k[1:0] == 2'h1;
            ex("oe", OE + 4, own);
            if (own) ex("out", OU + 4, rts);
        end
        m1 = 2'h1;
        rmp = 8'h80;
        ce = 4'h8;
        cho = 4'h0;
        rts = 1'b1;
        tick(2);
        ex("out", OU + 4, 1'b0);
        for (int k = 0; k < 6; k++) begin
            rmp = 8'h0;
            ce = 4'h0;
            m1 = 2'h2;
            m2 = 2'h2;
            s2 = k[0] ? 8'h10 : 8'h00;
            tx = 5'($random(seed));
            ext = 5'($random(seed));
            tick(4);
            if (k[0]) begin
                ex("out", OU, tx.master_out);
                ex("out", OU + 2, tx.spi_clock);
                ex("rx", RX + 3, ext[1]);
                ex("ss2", S2, 1'b1);
            end else begin
                ex("out", OU + 1, tx.master_in);
                ex("rx", RX + 4, ext[0]);
                ex("rx", RX + 2, ext[2]);
                ex("ss2", S2, ext[3]);
            end
            ex("oe", OE, k[0]);
            ex("oe", OE + 1, !k[0]);
            ex("ss1", S1, ext[4]);
        end
        cho = {4{~tx.master_out}};
        ce = 4'h1;
        tick(2);
        ex("out", OU, cho[0]);
        rmp = 8'h10;
        tick(2);
        ex("out", OU, tx.master_out);
        m2 = 2'h3;
        pa = 16'h9dd9;
        for (int k = 0; k < 4; k++) begin
            tx = '0;
            tx.twowire_data = k[0];
            tx.twowire_clock = k[1];
            ext = 5'($random(seed));
            tick(4);
            ex("oe", OE + 1, !k[0]);
            ex("oe", OE + 2, !k[1]);
            ex("out", OU + 1, 1'b0);
            ex("rx", RX + 1, k[0] & ext[1]);
            ex("oe", OE, 1'b0);
        end
        pa = 16'h9999;
        tx = '0;
        tick(2);
        ex("oe", OE + 1, 1'b0);
        m2 = 2'h0;
        pa = 16'h5100;
        gout = 5'($random(seed));
        tick(4);
        ex("usbm", UM, 1'b1);
        ex("usbp", UP, 1'b1);
        ex("gpio", GI, 1'b0);
        ex("out", OU + 2, gout[2]);
        ex("oe", OE + 3, !gout[3]);
        pa = 16'h4444;
        pb = 4'h4;
        ext = 5'($random(seed));
        tick(4);
        ex("usbp", UP, 1'b0);
        for (int k = 0; k < 8; k++) begin
            isc = k[2:0];
            isd = 3'h7 - k[2:0];
            tick(4);
            ex("ext_interrupt_c", IC, k < 5 ? ext[k] : 1'b0);
            ex("ext_interrupt_d", ID, k > 2 ? ext[7 - k] : 1'b0);
        end
        tick(2);
        finish_test();
    end
endmodule
